/* logic/cfc_pkg.sv */
package cfc_pkg;

    // Flag bit positions inside the flag word
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_AC = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_W = 4;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    // Highest data memory byte that takes bit operations
    localparam logic [7:0] BIT_ADDR_MAX = 8'h7f;

    // Instruction cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    // Instruction classes presented to the core
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_MOV_A_IMM = 6'h01,
        OP_MOV_A_MEM = 6'h02,
        OP_MOV_A_IO = 6'h03,
        OP_MOV_MEM_A = 6'h04,
        OP_MOV_IO_A = 6'h05,
        OP_TIMER_WORD_LOAD = 6'h06,
        OP_TIMER_WORD_STORE = 6'h07,
        OP_IDXM_RD = 6'h08,
        OP_IDXM_WR = 6'h09,
        OP_XCH = 6'h0a,
        OP_PUSHAF = 6'h0b,
        OP_POPAF = 6'h0c,
        OP_ADD = 6'h0d,
        OP_ADDC = 6'h0e,
        OP_SUB = 6'h0f,
        OP_SUBC = 6'h10,
        OP_NADD = 6'h11,
        OP_INC = 6'h12,
        OP_DEC = 6'h13,
        OP_SR = 6'h14,
        OP_SRC = 6'h15,
        OP_SL = 6'h16,
        OP_SLC = 6'h17,
        OP_AND = 6'h18,
        OP_OR = 6'h19,
        OP_XOR = 6'h1a,
        OP_NOT = 6'h1b,
        OP_NEG = 6'h1c,
        OP_COMP = 6'h1d,
        OP_CMP_EQ_SKIP = 6'h1e,
        OP_CMP_NE_SKIP = 6'h1f,
        OP_SET0 = 6'h20,
        OP_SET1 = 6'h21,
        OP_SWAPC = 6'h22,
        OP_TEST_LOW_SKIP = 6'h23,
        OP_TEST_HIGH_SKIP = 6'h24,
        OP_INC_SKIP_ZERO = 6'h25,
        OP_DEC_SKIP_ZERO = 6'h26,
        OP_GOTO = 6'h27,
        OP_CALL = 6'h28,
        OP_RET = 6'h29,
        OP_RET_IMM = 6'h2a,
        OP_RETI = 6'h2b,
        OP_PCADD = 6'h2c,
        OP_ENGINT = 6'h2d,
        OP_DISGINT = 6'h2e,
        OP_CLEAR = 6'h2f,
        OP_SWAP = 6'h30
    } cfc_op_e;

    // Fetch slot states
    typedef enum logic {
        ST_EXEC = 1'b0,
        ST_DISCARD = 1'b1
    } cfc_slot_e;

endpackage

/* logic/cfc_alu.sv */
`timescale 1ns/100ps
module cfc_alu
    import cfc_pkg::*;
(
    // Operands
    input wire logic [7:0] x,
    input wire logic [7:0] y,
    input wire logic cin,
    input wire logic sub,
    // Result and flags
    output logic [7:0] res,
    output logic [FLAG_W-1:0] flg
);
    logic [7:0] yy;
    logic ci;
    logic [8:0] sum9;
    logic [4:0] nib;

    // Subtraction is x + ~y + ~borrow; carry outputs inverted become borrows
    always_comb begin
        yy = sub ? ~y : y;
        ci = sub ? ~cin : cin;
        sum9 = {1'b0, x} + {1'b0, yy} + {8'h00, ci};
        nib = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};
        res = sum9[7:0];
        flg = '0;
        flg[FLAG_Z] = (sum9[7:0] == BYTE_ZERO);
        flg[FLAG_C] = sum9[8] ^ sub;
        flg[FLAG_AC] = nib[4] ^ sub;
        flg[FLAG_OV] = (x[7] == yy[7]) && (sum9[7] != x[7]);
    end
endmodule

/* logic/cfc_slot_ctl.sv */
`timescale 1ns/100ps
module cfc_slot_ctl
    import cfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction start and its cycle count
    input wire logic start,
    input wire logic [1:0] cycles,
    // Fetch slot being dropped
    output logic discard
);
    typedef struct packed {
        cfc_slot_e st;
        logic [1:0] left;
    } cfc_slot_s;

    cfc_slot_s s_q;
    cfc_slot_s s_d;

    // Extra cycles run as dropped fetch slots
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            ST_EXEC: begin
                if (start && (cycles > CYC_ONE)) begin
                    s_d.st = ST_DISCARD;
                    s_d.left = cycles - CYC_ONE;
                end
            end
            ST_DISCARD: begin
                s_d.left = s_q.left - CYC_ONE;
                if (s_q.left == CYC_ONE) begin
                    s_d.st = ST_EXEC;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{st: ST_EXEC, left: 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign discard = (s_q.st == ST_DISCARD);
endmodule

/* logic/cfc_core.sv */
`timescale 1ns/100ps
// How it works
// RULE1: Jumps, calls, indexed moves, pc add, returns take two cycles; others one.
// RULE2: Skip instructions take two cycles when skipping, one cycle otherwise.
// RULE3: Add, subtract, negated add, increment and decrement update all four flags.
// RULE4: Compares and compare-skips set all flags from subtraction, result not stored.
// RULE5: Shifts and rotates through carry change only the carry flag.
// RULE6: Logic ops, complement and negate change only zero; and, or, xor into IO none.
// RULE7: Loads into accumulator from memory or IO set zero; other moves none.
// RULE8: Push leaves flags alone; pop restores all four flags from the stack.
// RULE9: Swap IO bit with carry changes carry only; bit set, clear, test none.
// RULE10: Increment or decrement and skip on zero writes back and sets all flags.
// RULE11: Bit operations on data memory only reach bytes 0x00 to 0x7F.
// RULE12: Interrupt return turns global interrupt enable back on after it completes.
// RULE13: Compare-equal skip drops the following instruction when accumulator matches.
// RULE14: The second cycle of a two-cycle instruction is a dropped fetch slot.
// RULE15: Flags not touched by an instruction keep their old value exactly.
module cfc_core
    import cfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction slot
    input wire logic instr_valid,
    input wire cfc_op_e instr_op,
    input wire logic instr_to_mem,
    input wire logic instr_is_io,
    input wire logic [7:0] instr_operand,
    input wire logic [7:0] instr_addr,
    input wire logic [2:0] instr_bit,
    input wire logic [FLAG_W-1:0] instr_flags,
    // Architectural state
    output logic [7:0] acc,
    output logic [FLAG_W-1:0] flags,
    output logic gie,
    // Data write-back
    output logic mem_we,
    output logic io_we,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    // Sequencing and status
    output logic slot_discard,
    output logic pc_jump,
    output logic skip_taken,
    output logic push_we,
    output logic gie_set,
    output logic bit_fault
);
    typedef struct packed {
        logic [7:0] acc;
        logic [FLAG_W-1:0] flags;
        logic gie;
        logic reti_pend;
        logic mem_we;
        logic io_we;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic pc_jump;
        logic skip_taken;
        logic push_we;
        logic gie_set;
        logic bit_fault;
    } cfc_core_s;

    cfc_core_s s_q;
    cfc_core_s s_d;

    logic exec;
    logic [7:0] u;
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic [7:0] alu_x;
    logic [7:0] alu_y;
    logic alu_cin;
    logic alu_sub;
    logic [7:0] alu_res;
    logic [FLAG_W-1:0] alu_flg;
    logic bit_ok;
    logic bit_val;
    logic [7:0] bit_mask;
    logic wb_en;
    logic [7:0] wb_val;
    logic [FLAG_W-1:0] nf;
    logic [1:0] cycles;
    logic skip;

    // Ops that run the adder as a subtractor
    function automatic logic op_is_sub(input cfc_op_e op);
        return (op == OP_SUB) || (op == OP_SUBC) || (op == OP_NADD) || (op == OP_DEC) ||
               (op == OP_DEC_SKIP_ZERO) || (op == OP_COMP) || (op == OP_CMP_EQ_SKIP) ||
               (op == OP_CMP_NE_SKIP);
    endfunction

    // Ops that step a single value by one
    function automatic logic op_is_step(input cfc_op_e op);
        return (op == OP_INC) || (op == OP_DEC) || (op == OP_INC_SKIP_ZERO) || (op == OP_DEC_SKIP_ZERO);
    endfunction

    // Zero flag replaced, others kept
    function automatic logic [FLAG_W-1:0] with_zero(input logic [FLAG_W-1:0] f, input logic [7:0] v);
        logic [FLAG_W-1:0] r;
        r = f;
        r[FLAG_Z] = (v == BYTE_ZERO);
        return r;
    endfunction

    // Carry flag replaced, others kept
    function automatic logic [FLAG_W-1:0] with_carry(input logic [FLAG_W-1:0] f, input logic c);
        logic [FLAG_W-1:0] r;
        r = f;
        r[FLAG_C] = c;
        return r;
    endfunction

    // Instructions are taken only outside dropped slots
    assign exec = instr_valid && !slot_discard; // [RULE14]

    // Operand selection: memory forms put the memory byte first
    assign u = instr_to_mem ? instr_operand : s_q.acc;
    assign lhs = instr_to_mem ? instr_operand : s_q.acc;
    assign rhs = instr_to_mem ? s_q.acc : instr_operand;
    assign alu_x = (instr_op == OP_NADD) ? rhs : (op_is_step(instr_op) ? u : lhs);
    assign alu_y = (instr_op == OP_NADD) ? lhs : (op_is_step(instr_op) ? BYTE_ONE : rhs);
    assign alu_cin = ((instr_op == OP_ADDC) || (instr_op == OP_SUBC)) ? s_q.flags[FLAG_C] : 1'b0;
    assign alu_sub = op_is_sub(instr_op);

    // Bit selection; memory bits limited to the low half of the byte space
    assign bit_ok = instr_is_io || (instr_addr <= BIT_ADDR_MAX); // [RULE11]
    assign bit_val = instr_operand[instr_bit];
    assign bit_mask = BYTE_ONE << instr_bit;

    cfc_alu u_alu (
        .x(alu_x),
        .y(alu_y),
        .cin(alu_cin),
        .sub(alu_sub),
        .res(alu_res),
        .flg(alu_flg)
    );

    cfc_slot_ctl u_slot (
        .clk(clk),
        .resetn(resetn),
        .start(exec),
        .cycles(cycles),
        .discard(slot_discard)
    );

    // Decode, execute and flag update
    always_comb begin
        s_d = s_q;
        s_d.mem_we = 1'b0;
        s_d.io_we = 1'b0;
        s_d.pc_jump = 1'b0;
        s_d.skip_taken = 1'b0;
        s_d.push_we = 1'b0;
        s_d.gie_set = 1'b0;
        s_d.bit_fault = 1'b0;
        wb_en = 1'b0;
        wb_val = s_q.acc;
        nf = s_q.flags; // [RULE15]
        cycles = CYC_ONE; // [RULE1]
        skip = 1'b0;
        // Interrupt enable returns once the return has finished its slot
        if (s_q.reti_pend) begin
            s_d.gie = 1'b1; // [RULE12]
            s_d.gie_set = 1'b1;
            s_d.reti_pend = 1'b0;
        end
        if (exec) begin
            unique case (instr_op)
                OP_MOV_A_IMM: s_d.acc = instr_operand; // [RULE7]
                OP_MOV_A_MEM, OP_MOV_A_IO: begin
                    s_d.acc = instr_operand;
                    nf = with_zero(s_q.flags, instr_operand); // [RULE7]
                end
                OP_MOV_MEM_A, OP_MOV_IO_A, OP_IDXM_WR: begin
                    s_d.mem_we = (instr_op != OP_MOV_IO_A);
                    s_d.io_we = (instr_op == OP_MOV_IO_A);
                    s_d.wr_addr = instr_addr;
                    s_d.wr_data = s_q.acc;
                    cycles = (instr_op == OP_IDXM_WR) ? CYC_TWO : CYC_ONE; // [RULE1]
                end
                OP_IDXM_RD: begin
                    s_d.acc = instr_operand;
                    cycles = CYC_TWO; // [RULE1]
                end
                OP_XCH: begin
                    s_d.acc = instr_operand;
                    s_d.mem_we = 1'b1;
                    s_d.wr_addr = instr_addr;
                    s_d.wr_data = s_q.acc;
                end
                OP_PUSHAF: s_d.push_we = 1'b1; // [RULE8]
                OP_POPAF: begin
                    s_d.acc = instr_operand;
                    nf = instr_flags; // [RULE8]
                end
                OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_NADD, OP_INC, OP_DEC: begin
                    wb_en = 1'b1;
                    wb_val = alu_res;
                    nf = alu_flg; // [RULE3]
                end
                OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO: begin
                    wb_en = 1'b1;
                    wb_val = alu_res;
                    nf = alu_flg; // [RULE10]
                    skip = alu_flg[FLAG_Z];
                end
                OP_COMP: nf = alu_flg; // [RULE4]
                OP_CMP_EQ_SKIP, OP_CMP_NE_SKIP: begin
                    nf = alu_flg; // [RULE4]
                    skip = (instr_op == OP_CMP_EQ_SKIP) ? alu_flg[FLAG_Z] : !alu_flg[FLAG_Z]; // [RULE13]
                end
                OP_SR, OP_SRC, OP_SL, OP_SLC: begin
                    wb_en = 1'b1;
                    unique case (instr_op)
                        OP_SR: wb_val = {1'b0, u[7:1]};
                        OP_SRC: wb_val = {s_q.flags[FLAG_C], u[7:1]};
                        OP_SL: wb_val = {u[6:0], 1'b0};
                        default: wb_val = {u[6:0], s_q.flags[FLAG_C]};
                    endcase
                    nf = with_carry(s_q.flags, ((instr_op == OP_SR) || (instr_op == OP_SRC)) ? u[0] : u[7]); // [RULE5]
                end
                OP_AND, OP_OR, OP_XOR: begin
                    wb_en = 1'b1;
                    wb_val = (instr_op == OP_AND) ? (s_q.acc & instr_operand) :
                             (instr_op == OP_OR) ? (s_q.acc | instr_operand) : (s_q.acc ^ instr_operand);
                    if (!(instr_to_mem && instr_is_io)) begin
                        nf = with_zero(s_q.flags, wb_val); // [RULE6]
                    end
                end
                OP_NOT, OP_NEG: begin
                    wb_en = 1'b1;
                    wb_val = (instr_op == OP_NOT) ? ~u : (BYTE_ZERO - u);
                    nf = with_zero(s_q.flags, wb_val); // [RULE6]
                end
                OP_SET0, OP_SET1, OP_SWAPC: begin
                    if (bit_ok) begin
                        s_d.mem_we = !instr_is_io;
                        s_d.io_we = instr_is_io;
                        s_d.wr_addr = instr_addr;
                        s_d.wr_data = ((instr_op == OP_SET1) ||
                                       ((instr_op == OP_SWAPC) && s_q.flags[FLAG_C])) ?
                                      (instr_operand | bit_mask) : (instr_operand & ~bit_mask); // [RULE9]
                        if (instr_op == OP_SWAPC) begin
                            nf = with_carry(s_q.flags, bit_val); // [RULE9]
                        end
                    end else begin
                        s_d.bit_fault = 1'b1; // [RULE11]
                    end
                end
                OP_TEST_LOW_SKIP, OP_TEST_HIGH_SKIP: begin
                    if (bit_ok) begin
                        skip = (instr_op == OP_TEST_HIGH_SKIP) ? bit_val : !bit_val; // [RULE9]
                    end else begin
                        s_d.bit_fault = 1'b1; // [RULE11]
                    end
                end
                OP_GOTO, OP_CALL, OP_RET, OP_PCADD: begin
                    s_d.pc_jump = 1'b1;
                    cycles = CYC_TWO; // [RULE1]
                end
                OP_RET_IMM: begin
                    s_d.acc = instr_operand;
                    s_d.pc_jump = 1'b1;
                    cycles = CYC_TWO; // [RULE1]
                end
                OP_RETI: begin
                    s_d.pc_jump = 1'b1;
                    s_d.reti_pend = 1'b1; // [RULE12]
                    cycles = CYC_TWO; // [RULE1]
                end
                OP_ENGINT: s_d.gie = 1'b1;
                OP_DISGINT: s_d.gie = 1'b0;
                OP_CLEAR: begin
                    s_d.mem_we = 1'b1;
                    s_d.wr_addr = instr_addr;
                    s_d.wr_data = BYTE_ZERO;
                end
                OP_SWAP: s_d.acc = {s_q.acc[3:0], s_q.acc[7:4]};
                default: cycles = CYC_ONE; // [RULE1]
            endcase
            // Write-back to accumulator, memory or IO
            if (wb_en) begin
                if (instr_to_mem) begin
                    s_d.mem_we = !instr_is_io;
                    s_d.io_we = instr_is_io;
                    s_d.wr_addr = instr_addr;
                    s_d.wr_data = wb_val;
                end else begin
                    s_d.acc = wb_val;
                end
            end
            // A taken skip costs one dropped slot
            if (skip) begin
                cycles = CYC_TWO; // [RULE2]
                s_d.skip_taken = 1'b1;
            end
        end
        s_d.flags = nf;
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{acc: ACC_RST, flags: FLAGS_RST, wr_addr: BYTE_ZERO, wr_data: BYTE_ZERO, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign acc = s_q.acc;
    assign flags = s_q.flags;
    assign gie = s_q.gie;
    assign mem_we = s_q.mem_we;
    assign io_we = s_q.io_we;
    assign wr_addr = s_q.wr_addr;
    assign wr_data = s_q.wr_data;
    assign pc_jump = s_q.pc_jump;
    assign skip_taken = s_q.skip_taken;
    assign push_we = s_q.push_we;
    assign gie_set = s_q.gie_set;
    assign bit_fault = s_q.bit_fault;
endmodule

/* tb/cfc_core_chk.sv */
`timescale 1ns/100ps
module cfc_core_chk
    import cfc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction slot
    input wire logic instr_valid,
    input wire cfc_op_e instr_op,
    input wire logic instr_is_io,
    input wire logic [7:0] instr_addr,
    input wire logic [FLAG_W-1:0] instr_flags,
    // Watched outputs
    input wire logic [FLAG_W-1:0] flags,
    input wire logic gie,
    input wire logic mem_we,
    input wire logic io_we,
    input wire logic slot_discard,
    input wire logic pc_jump,
    input wire logic skip_taken,
    input wire logic push_we,
    input wire logic gie_set,
    input wire logic bit_fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Instruction accepted at this edge
    logic take;
    assign take = instr_valid && !slot_discard;
    // Interrupt return: jump with dropped slot, then enable
    sequence s_reti_take;
        take && instr_op == OP_RETI;
    endsequence
    sequence s_reti_done;
        pc_jump && slot_discard ##1 gie && gie_set;
    endsequence
    chk_reti_gie_walk: assert property (s_reti_take |=> s_reti_done) else $error("reti walk wrong");
    chk_jump_drops_slot: assert property (pc_jump |-> slot_discard) else $error("jump without drop");
    chk_skip_drops_slot: assert property (skip_taken |-> slot_discard) else $error("skip without drop");
    chk_drop_one_cycle: assert property (slot_discard |=> !slot_discard) else $error("drop too long");
    chk_drop_has_cause: assert property (slot_discard |-> $past(take)) else $error("drop without cause");
    chk_drop_no_change: assert property (slot_discard |=> $stable(flags) && !mem_we && !io_we)
        else $error("state changed in dropped slot");
    chk_bit_range_fault: assert property (take && !instr_is_io && instr_addr > BIT_ADDR_MAX
        && instr_op inside {OP_SET0, OP_SET1, OP_SWAPC, OP_TEST_LOW_SKIP, OP_TEST_HIGH_SKIP}
        |=> bit_fault && !mem_we && !skip_taken && $stable(flags)) else $error("bit op out of range");
    chk_push_keeps_flags: assert property (take && instr_op == OP_PUSHAF |=> push_we && $stable(flags))
        else $error("push changed flags");
    chk_pop_restores_flags: assert property (take && instr_op == OP_POPAF |=> flags == $past(instr_flags))
        else $error("pop flags wrong");
    chk_shift_carry_only: assert property (take && instr_op inside {OP_SR, OP_SRC, OP_SL, OP_SLC}
        |=> (flags & 4'hd) == ($past(flags) & 4'hd)) else $error("shift touched flags");
endmodule

bind cfc_core cfc_core_chk u_chk (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_is_io(instr_is_io), .instr_addr(instr_addr), .instr_flags(instr_flags), .flags(flags), .gie(gie),
    .mem_we(mem_we), .io_we(io_we), .slot_discard(slot_discard), .pc_jump(pc_jump), .skip_taken(skip_taken),
    .push_we(push_we), .gie_set(gie_set), .bit_fault(bit_fault));

/* tb/cfc_mem_model.sv */
`timescale 1ns/100ps
module cfc_mem_model (
    // Clock
    input wire logic clk,
    // Write port from the core
    input wire logic mem_we,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read port for the bench
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [256];
    // Filled with a marker so a missing write shows
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'ha5;
        end
    end
    // Byte write on the core's pulse
    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            mem[wr_addr] <= wr_data;
        end
    end
    assign rd_data = mem[rd_addr];
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import cfc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    cfc_op_e instr_op = OP_NOP;
    logic instr_to_mem = 1'b0;
    logic instr_is_io = 1'b0;
    logic [7:0] instr_operand = 8'h00;
    logic [7:0] instr_addr = 8'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [3:0] instr_flags = 4'h0;
    logic [7:0] acc, wr_addr, wr_data, rd_data;
    logic [3:0] flags;
    logic gie, mem_we, io_we, slot_discard, pc_jump, skip_taken, push_we, gie_set, bit_fault;
    int mismatches = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    cfc_core DUT (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_to_mem(instr_to_mem), .instr_is_io(instr_is_io), .instr_operand(instr_operand),
        .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_flags(instr_flags), .acc(acc), .flags(flags),
        .gie(gie), .mem_we(mem_we), .io_we(io_we), .wr_addr(wr_addr), .wr_data(wr_data),
        .slot_discard(slot_discard), .pc_jump(pc_jump), .skip_taken(skip_taken), .push_we(push_we),
        .gie_set(gie_set), .bit_fault(bit_fault));
    cfc_mem_model u_mem (.clk(clk), .mem_we(mem_we), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(instr_addr), .rd_data(rd_data));
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Wide enough for accumulator and flags side by side
    task automatic cmp_byte(logic [15:0] got, logic [15:0] exp, string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(logic got, logic exp, string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    // Offer one instruction at the falling edge; returns once its results show
    task automatic issue(cfc_op_e op, logic tm, logic io, logic [7:0] opd, logic [7:0] ad, logic [2:0] b);
        instr_valid = 1'b1;
        instr_op = op;
        instr_to_mem = tm;
        instr_is_io = io;
        instr_operand = opd;
        instr_addr = ad;
        instr_bit = b;
        @(negedge clk);
    endtask
    task automatic idle();
        instr_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic pop(logic [3:0] f);
        instr_flags = f;
        issue(OP_POPAF, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
    endtask
    task automatic lda(logic [7:0] v);
        issue(OP_MOV_A_IMM, 1'b0, 1'b0, v, 8'h00, 3'h0);
    endtask
    task automatic t_reset();
        cmp_byte(acc, ACC_RST, "acc");
        cmp_byte({4'h0, flags}, 8'h00, "flags");
        cmp_bit(gie, 1'b0, "gie");
        cmp_bit(slot_discard, 1'b0, "drop");
    endtask
    task automatic t_arith();
        pop(4'h5);
        issue(OP_PUSHAF, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        lda(8'h7f);
        cmp_byte({4'h0, flags}, 8'h05, "imm load flags");
        issue(OP_ADD, 1'b0, 1'b0, 8'h01, 8'h00, 3'h0);
        cmp_byte(acc, 8'h80, "add acc");
        cmp_byte({4'h0, flags}, 8'h0c, "add flags");
        issue(OP_ADD, 1'b1, 1'b0, 8'h80, 8'h20, 3'h0);
        cmp_byte({4'h0, flags}, 8'h0b, "add mem flags");
        cmp_bit(mem_we, 1'b1, "add mem we");
        cmp_byte(wr_addr, 8'h20, "add mem addr");
        idle();
        cmp_byte(rd_data, 8'h00, "mem sum");
        pop(4'hd);
        lda(8'h80);
        issue(OP_SL, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'h000f, "shift");
        pop(4'he);
        lda(8'h0f);
        issue(OP_AND, 1'b0, 1'b0, 8'hf0, 8'h00, 3'h0);
        cmp_byte({4'h0, flags}, 8'h0f, "and flags");
        pop(4'h0);
        issue(OP_XOR, 1'b1, 1'b1, 8'h0f, 8'h05, 3'h0);
        cmp_byte({4'h0, flags}, 8'h00, "xor io flags");
        cmp_bit(io_we, 1'b1, "xor io we");
        issue(OP_MOV_A_MEM, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'h0001, "mov mem");
    endtask
    task automatic t_two_cycle();
        cfc_op_e ops [6] = '{OP_GOTO, OP_CALL, OP_RET, OP_PCADD, OP_IDXM_RD, OP_IDXM_WR};
        logic jmp [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++) begin
            lda(8'h00);
            cmp_bit(slot_discard, 1'b0, "one cycle");
            issue(ops[i], 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
            cmp_bit(slot_discard, 1'b1, "two cycle");
            cmp_bit(pc_jump, jmp[i], "jump");
            lda(8'h55);
            cmp_byte(acc, 8'h00, "dropped slot");
        end
        cmp_byte({4'h0, flags}, 8'h01, "flags kept");
        issue(OP_ENGINT, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        issue(OP_DISGINT, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        cmp_bit(gie, 1'b0, "gie off");
        issue(OP_RETI, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        idle();
        cmp_bit(gie & gie_set, 1'b1, "reti gie");
    endtask
    task automatic t_skip();
        pop(4'h0);
        lda(8'h38);
        issue(OP_CMP_EQ_SKIP, 1'b0, 1'b0, 8'h38, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'h3801, "ceq equal");
        cmp_bit(skip_taken & slot_discard, 1'b1, "ceq skip");
        idle();
        issue(OP_CMP_EQ_SKIP, 1'b0, 1'b0, 8'h42, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'h3802, "ceq differ");
        cmp_bit(skip_taken | slot_discard, 1'b0, "ceq no skip");
        issue(OP_CMP_NE_SKIP, 1'b0, 1'b0, 8'h42, 8'h00, 3'h0);
        cmp_bit(skip_taken & slot_discard, 1'b1, "cne skip");
        idle();
        lda(8'hff);
        issue(OP_INC_SKIP_ZERO, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'h0007, "inc skip");
        cmp_bit(skip_taken, 1'b1, "inc skip taken");
        idle();
        issue(OP_DEC_SKIP_ZERO, 1'b0, 1'b0, 8'h00, 8'h00, 3'h0);
        cmp_byte({acc, 4'h0, flags}, 16'hff06, "dec skip");
        cmp_bit(skip_taken, 1'b0, "dec no skip");
    endtask
    task automatic t_bits();
        pop(4'h0);
        issue(OP_SET1, 1'b1, 1'b0, 8'h00, 8'h7f, 3'h3);
        cmp_byte({mem_we, bit_fault, flags, 2'h0}, 8'h80, "set1 top");
        cmp_byte(wr_data, 8'h08, "set1 data");
        issue(OP_SET0, 1'b1, 1'b0, 8'hff, 8'h10, 3'h7);
        cmp_byte(wr_data, 8'h7f, "set0 data");
        issue(OP_SET1, 1'b1, 1'b0, 8'h00, 8'h80, 3'h3);
        cmp_byte({mem_we, bit_fault}, 8'h01, "set1 beyond");
        issue(OP_TEST_LOW_SKIP, 1'b0, 1'b0, 8'h00, 8'h80, 3'h0);
        cmp_byte({skip_taken, bit_fault}, 8'h01, "test beyond");
        issue(OP_TEST_HIGH_SKIP, 1'b0, 1'b0, 8'h01, 8'h10, 3'h0);
        cmp_byte({skip_taken, flags}, 8'h10, "test high");
        idle();
        issue(OP_SWAPC, 1'b1, 1'b1, 8'h04, 8'h06, 3'h2);
        cmp_byte({io_we, flags, wr_data[2]}, 8'h24, "swapc");
        idle();
    endtask
    // Cut a hang short
    initial begin
        #(2000 * 25);
        mismatches++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_arith();
        t_two_cycle();
        t_skip();
        t_bits();
        results();
    end
endmodule
